// file: branch_and_bit_op_exec.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "exec_defs.svh"

module branch_and_bit_op_exec
    import exec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic opValid,
    output logic opReady,
    input wire op_t opCode,
    input wire logic [`OFFSET_WIDTH-1:0] branchOffset,
    input wire logic [2:0] bitSel,
    input wire logic [`REG_INDEX_WIDTH-1:0] regIndex,
    input wire logic [`IO_ADDR_WIDTH-1:0] ioAddr,
    input wire logic [7:0] rdValue,
    input wire logic [7:0] rrValue,
    output logic ioReadStrobe,
    output logic [`IO_ADDR_WIDTH-1:0] ioReadAddr,
    input wire logic [7:0] ioReadData,
    output logic ioWriteStrobe,
    output logic [`IO_ADDR_WIDTH-1:0] ioWriteAddr,
    output logic [7:0] ioWriteData,
    output logic rdWrite,
    output logic [`REG_INDEX_WIDTH-1:0] rdWriteIndex,
    output logic [7:0] rdWriteData,
    input wire logic flagsLoad,
    input wire logic [7:0] flagsLoadData,
    output logic [`PC_WIDTH-1:0] pc,
    output logic [7:0] flags,
    output logic opDone
);
    typedef struct packed {
        phase_t phase;
        logic [`PC_WIDTH-1:0] pc;
        logic [7:0] flags;
        logic rdWrite;
        logic [`REG_INDEX_WIDTH-1:0] rdIndex;
        logic [7:0] rdData;
        logic ioWrite;
        logic [`IO_ADDR_WIDTH-1:0] ioWrAddr;
        logic [7:0] ioWrData;
        logic [`IO_ADDR_WIDTH-1:0] ioHeldAddr;
        logic [2:0] ioHeldBit;
        logic ioSet;
        logic fwdHit;
        logic [7:0] fwdData;
        logic opDone;
    } exec_state_t;

    exec_state_t cur;
    exec_state_t next_cur;

    logic accept;
    logic take;
    logic [7:0] unitResult;
    logic [7:0] unitFlags;
    logic [7:0] ioOld;
    logic [`PC_WIDTH-1:0] pcPlusOne;
    logic [`PC_WIDTH-1:0] jumpTarget;

    function automatic logic [`PC_WIDTH-1:0] relTarget(
        input logic [`PC_WIDTH-1:0] base,
        input logic [`OFFSET_WIDTH-1:0] k
    );
        logic [`PC_WIDTH-1:0] ext;
        ext = {{(`PC_WIDTH-`OFFSET_WIDTH){k[`OFFSET_WIDTH-1]}}, k};
        relTarget = base + ext + `PC_WIDTH'(1);
    endfunction : relTarget

    branch_cond condEval (
        .opCode(opCode),
        .flags(cur.flags),
        .take(take)
    );

    shift_unit shifter (
        .opCode(opCode),
        .operand(rdValue),
        .flagsIn(cur.flags),
        .bitSel(bitSel),
        .result(unitResult),
        .flagsOut(unitFlags)
    );

    assign opReady = (cur.phase == PH_IDLE);
    assign accept = opValid && opReady;
    assign ioReadStrobe = accept && ((opCode == IO_BIT_SET_OP) || (opCode == IO_BIT_CLEAR_OP));
    assign ioReadAddr = ioAddr;
    assign pcPlusOne = cur.pc + `PC_WIDTH'(1);
    assign jumpTarget = relTarget(cur.pc, branchOffset);
    // a write issued beside our read lands too late for the read data
    assign ioOld = cur.fwdHit ? cur.fwdData : ioReadData;

    always_comb begin
        next_cur = cur;
        next_cur.rdWrite = 1'b0;
        next_cur.ioWrite = 1'b0;
        next_cur.opDone = 1'b0;
        if (flagsLoad) begin
            next_cur.flags = flagsLoadData;
        end
        case (cur.phase)
            PH_IDLE: begin
                if (accept) begin
                    next_cur.pc = pcPlusOne;
                    if (isBranch(opCode)) begin
                        if (take) begin
                            next_cur.pc = jumpTarget;
                            next_cur.phase = PH_FLUSH;
                        end else begin
                            next_cur.opDone = 1'b1;
                        end
                    end else if (ioReadStrobe) begin
                        next_cur.phase = PH_IO_MOD;
                        next_cur.ioHeldAddr = ioAddr;
                        next_cur.ioHeldBit = bitSel;
                        next_cur.ioSet = (opCode == IO_BIT_SET_OP);
                        next_cur.fwdHit = cur.ioWrite && (cur.ioWrAddr == ioAddr);
                        next_cur.fwdData = cur.ioWrData;
                    end else if (isRegOp(opCode)) begin
                        next_cur.rdWrite = 1'b1;
                        next_cur.rdIndex = regIndex;
                        next_cur.rdData = unitResult;
                        next_cur.flags = unitFlags;
                        next_cur.opDone = 1'b1;
                    end else begin
                        case (opCode)
                            FLAG_SET_OP: next_cur.flags[bitSel] = 1'b1;
                            FLAG_CLEAR_OP: next_cur.flags[bitSel] = 1'b0;
                            BIT_TO_TRANSFER_FLAG: next_cur.flags[`FLAG_T] = rrValue[bitSel];
                            default: next_cur.flags = next_cur.flags;
                        endcase
                        next_cur.opDone = 1'b1;
                    end
                end
            end
            PH_FLUSH: begin
                next_cur.phase = PH_IDLE;
                next_cur.opDone = 1'b1;
            end
            PH_IO_MOD: begin
                next_cur.ioWrite = 1'b1;
                next_cur.ioWrAddr = cur.ioHeldAddr;
                next_cur.ioWrData = ioOld;
                next_cur.ioWrData[cur.ioHeldBit] = cur.ioSet;
                next_cur.phase = PH_IDLE;
                next_cur.opDone = 1'b1;
            end
            default: next_cur.phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur <= '0;
            cur.phase <= PH_IDLE;
            cur.pc <= `PC_RESET;
            cur.flags <= `FLAGS_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign pc = cur.pc;
    assign flags = cur.flags;
    assign rdWrite = cur.rdWrite;
    assign rdWriteIndex = cur.rdIndex;
    assign rdWriteData = cur.rdData;
    assign ioWriteStrobe = cur.ioWrite;
    assign ioWriteAddr = cur.ioWrAddr;
    assign ioWriteData = cur.ioWrData;
    assign opDone = cur.opDone;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property branchRule(op_t o, logic cond);
        (accept && opCode == o && !flagsLoad)
            |=> pc == $past(pc) + 13'h1 + ($past(cond)
                ? {{(`PC_WIDTH-`OFFSET_WIDTH){$past(branchOffset[`OFFSET_WIDTH-1])}},
                $past(branchOffset)} : 13'h0)
                && flags == $past(flags);
    endproperty

    sequence takenStart;
        accept && isBranch(opCode) && take;
    endsequence

    sequence flushDone;
        !opReady && !opDone ##1 opReady && opDone;
    endsequence

    sequence ioStart(op_t o);
        accept && opCode == o && !flagsLoad ##1 !flagsLoad && !opReady;
    endsequence

    sequence ioPlainStart;
        accept && ioReadStrobe && !(ioWriteStrobe && ioWriteAddr == ioAddr);
    endsequence

    sequence ioFwdStart;
        accept && ioReadStrobe && ioWriteStrobe && ioWriteAddr == ioAddr;
    endsequence

    sequence shiftStart;
        accept && !flagsLoad && opCode >= SHIFT_LEFT_ZERO_FILL
            && opCode <= SHIFT_RIGHT_SIGN_KEEP;
    endsequence

    sequence oneStepOp;
        accept && !isBranch(opCode) && !ioReadStrobe;
    endsequence

    carry_zero_br_a: assert property (branchRule(BRANCH_CARRY_ZERO, !flags[`FLAG_C]))
        else $error("carry clear branch wrong target");
    same_higher_br_a: assert property (branchRule(BRANCH_SAME_OR_HIGHER, !flags[`FLAG_C]))
        else $error("same or higher branch wrong target");
    below_br_a: assert property (branchRule(BRANCH_BELOW, flags[`FLAG_C]))
        else $error("lower branch wrong target");
    negative_br_a: assert property (branchRule(BRANCH_NEGATIVE, flags[`FLAG_N]))
        else $error("minus branch wrong target");
    nonneg_br_a: assert property (branchRule(BRANCH_NONNEGATIVE, !flags[`FLAG_N]))
        else $error("plus branch wrong target");
    signed_ge_a: assert property (branchRule(BRANCH_SIGNED_GE,
        !(flags[`FLAG_N] ^ flags[`FLAG_V])))
        else $error("signed ge branch wrong target");
    signed_less_a: assert property (branchRule(BRANCH_SIGNED_LESS,
        flags[`FLAG_N] ^ flags[`FLAG_V]))
        else $error("signed less branch wrong target");
    hc_set_br_a: assert property (branchRule(BRANCH_HALFCARRY_SET, flags[`FLAG_H]))
        else $error("half carry set branch wrong target");
    hc_clear_br_a: assert property (branchRule(BRANCH_HALFCARRY_CLEAR, !flags[`FLAG_H]))
        else $error("half carry clear branch wrong target");
    tflag_br_a: assert property (branchRule(BRANCH_TRANSFER_FLAG_SET, flags[`FLAG_T]))
        else $error("transfer flag branch wrong target");
    irq_on_br_a: assert property (branchRule(BRANCH_IRQ_ON, flags[`FLAG_I]))
        else $error("irq enabled branch wrong target");
    irq_off_br_a: assert property (branchRule(BRANCH_IRQ_OFF, !flags[`FLAG_I]))
        else $error("irq disabled branch wrong target");

    taken_two_clk_a: assert property (takenStart |=> flushDone)
        else $error("taken branch not two clocks");
    skip_one_clk_a: assert property ((accept && isBranch(opCode) && !take)
        |=> opReady && opDone)
        else $error("untaken branch not one clock");
    busy_hold_a: assert property ((!opReady && !flagsLoad)
        |=> pc == $past(pc) && flags == $past(flags) && !rdWrite)
        else $error("busy cycle changed state");

    io_set_a: assert property (ioStart(IO_BIT_SET_OP) |=> ioWriteStrobe && opDone
        && ioWriteData[$past(bitSel, 2)] && ioWriteAddr == $past(ioAddr, 2)
        && flags == $past(flags, 2))
        else $error("io bit set wrong");
    io_clear_a: assert property (ioStart(IO_BIT_CLEAR_OP) |=> ioWriteStrobe && opDone
        && !ioWriteData[$past(bitSel, 2)] && flags == $past(flags, 2))
        else $error("io bit clear wrong");
    io_two_clk_a: assert property ((accept && ioReadStrobe) |=> flushDone)
        else $error("io op not two clocks");
    io_keep_a: assert property (ioPlainStart |-> ##2 ioWriteStrobe
        && (((ioWriteData ^ $past(ioReadData)) & ~(8'h01 << $past(bitSel, 2))) == 8'h00))
        else $error("io op changed other bits");
    io_forward_a: assert property (ioFwdStart |-> ##2 ioWriteStrobe
        && (((ioWriteData ^ $past(ioWriteData, 2)) & ~(8'h01 << $past(bitSel, 2))) == 8'h00))
        else $error("io op lost pending write");

    one_clk_op_a: assert property (oneStepOp
        |=> opReady && opDone && pc == $past(pc) + 13'h1)
        else $error("single clock op wrong timing");
    shift_flags_a: assert property (shiftStart |=> rdWrite
        && flags[`FLAG_Z] == (rdWriteData == 8'h00) && flags[`FLAG_N] == rdWriteData[7]
        && flags[`FLAG_V] == (rdWriteData[7] ^ flags[`FLAG_C])
        && flags[`FLAG_S] == $past(flags[`FLAG_S]))
        else $error("shift flags wrong");
    shl_zero_a: assert property ((accept && opCode == SHIFT_LEFT_ZERO_FILL)
        |=> rdWrite && rdWriteData == {$past(rdValue[6:0]), 1'b0}
        && flags[`FLAG_C] == $past(rdValue[7])
        && flags[`FLAG_V] == (flags[`FLAG_N] ^ flags[`FLAG_C]))
        else $error("left shift wrong");
    shr_zero_a: assert property ((accept && opCode == SHIFT_RIGHT_ZERO_FILL)
        |=> rdWriteData == {1'b0, $past(rdValue[7:1])} && !flags[`FLAG_N]
        && flags[`FLAG_Z] == (rdWriteData == 8'h00))
        else $error("right shift wrong");
    rol_carry_a: assert property ((accept && opCode == ROTATE_LEFT_CARRY)
        |=> rdWriteData == {$past(rdValue[6:0]), $past(flags[`FLAG_C])}
        && flags[`FLAG_C] == $past(rdValue[7]))
        else $error("rotate left wrong");
    ror_carry_a: assert property ((accept && opCode == ROTATE_RIGHT_CARRY)
        |=> rdWriteData == {$past(flags[`FLAG_C]), $past(rdValue[7:1])}
        && flags[`FLAG_C] == $past(rdValue[0]))
        else $error("rotate right wrong");
    asr_sign_a: assert property ((accept && opCode == SHIFT_RIGHT_SIGN_KEEP)
        |=> rdWriteData == {$past(rdValue[7]), $past(rdValue[7:1])}
        && flags[`FLAG_C] == $past(rdValue[0]))
        else $error("arithmetic shift wrong");
    nibble_swap_a: assert property ((accept && opCode == NIBBLE_EXCHANGE
        && !flagsLoad)
        |=> rdWriteData == {$past(rdValue[3:0]), $past(rdValue[7:4])}
        && flags == $past(flags))
        else $error("nibble swap wrong");
    flag_bit_a: assert property ((accept && !flagsLoad
        && (opCode == FLAG_SET_OP || opCode == FLAG_CLEAR_OP))
        |=> flags[$past(bitSel)] == ($past(opCode) == FLAG_SET_OP)
        && $countones(flags ^ $past(flags)) <= 1)
        else $error("flag set or clear wrong");
    bit_store_a: assert property ((accept && opCode == BIT_TO_TRANSFER_FLAG
        && !flagsLoad)
        |=> flags[`FLAG_T] == $past(rrValue[bitSel]) && !rdWrite
        && (flags | 8'h40) == ($past(flags) | 8'h40))
        else $error("bit store wrong");
    bit_load_a: assert property ((accept && opCode == TRANSFER_FLAG_TO_BIT
        && !flagsLoad)
        |=> rdWrite && rdWriteData[$past(bitSel)] == $past(flags[`FLAG_T])
        && rdWriteIndex == $past(regIndex) && flags == $past(flags))
        else $error("bit load wrong");

endmodule : branch_and_bit_op_exec

// file: branch_and_bit_op_exec_tb.sv
`timescale 1ns/1ps
`include "exec_defs.svh"

module branch_and_bit_op_exec_tb
    import exec_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic opValid = 1'b0;
    op_t opCode = OP_NOP;
    logic [`OFFSET_WIDTH-1:0] branchOffset = 7'h00;
    logic [2:0] bitSel = 3'h0;
    logic [`REG_INDEX_WIDTH-1:0] regIndex = 5'h00;
    logic [`IO_ADDR_WIDTH-1:0] ioAddr = 5'h00;
    logic [7:0] rdValue = 8'h00;
    logic [7:0] rrValue = 8'h00;
    logic [7:0] ioReadData = 8'h00;
    logic flagsLoad = 1'b0;
    logic [7:0] flagsLoadData = 8'h00;
    logic opReady;
    logic ioReadStrobe;
    logic [`IO_ADDR_WIDTH-1:0] ioReadAddr;
    logic ioWriteStrobe;
    logic [`IO_ADDR_WIDTH-1:0] ioWriteAddr;
    logic [7:0] ioWriteData;
    logic rdWrite;
    logic [`REG_INDEX_WIDTH-1:0] rdWriteIndex;
    logic [7:0] rdWriteData;
    logic [`PC_WIDTH-1:0] pc;
    logic [7:0] flags;
    logic opDone;
    int nErrors = 0;
    int cmpCount = 0;
    logic [`PC_WIDTH-1:0] expPc = 13'h0000;
    logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h04, 8'h08};

    branch_and_bit_op_exec dut (
        .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opReady(opReady),
        .opCode(opCode), .branchOffset(branchOffset), .bitSel(bitSel),
        .regIndex(regIndex), .ioAddr(ioAddr), .rdValue(rdValue), .rrValue(rrValue),
        .ioReadStrobe(ioReadStrobe), .ioReadAddr(ioReadAddr), .ioReadData(ioReadData),
        .ioWriteStrobe(ioWriteStrobe), .ioWriteAddr(ioWriteAddr),
        .ioWriteData(ioWriteData), .rdWrite(rdWrite), .rdWriteIndex(rdWriteIndex),
        .rdWriteData(rdWriteData), .flagsLoad(flagsLoad), .flagsLoadData(flagsLoadData),
        .pc(pc), .flags(flags), .opDone(opDone)
    );

    always #50 ref_clk = ~ref_clk;

    task automatic stopTest;
        if (nErrors == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stopTest

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic setFlags(input logic [7:0] v);
        @(posedge ref_clk);
        flagsLoad <= 1'b1;
        flagsLoadData <= v;
        @(posedge ref_clk);
        flagsLoad <= 1'b0;
    endtask : setFlags

    // offers one op, holds it to the accept edge, checks completion timing
    task automatic runOp(input op_t op, input logic [6:0] k, input logic [2:0] b,
            input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] iod,
            input logic twoCyc);
        logic isIo;
        isIo = (op == IO_BIT_SET_OP) || (op == IO_BIT_CLEAR_OP);
        @(posedge ref_clk);
        opValid <= 1'b1;
        opCode <= op;
        branchOffset <= k;
        bitSel <= b;
        regIndex <= 5'h0b;
        ioAddr <= 5'h1a;
        rdValue <= rd;
        rrValue <= rr;
        #1;
        check(opReady, 1'b1);
        check(ioReadStrobe, isIo);
        if (isIo) begin
            check(ioReadAddr, 5'h1a);
        end
        @(posedge ref_clk);
        opValid <= 1'b0;
        ioReadData <= iod;
        #1;
        check(opDone, !twoCyc);
        check(opReady, !twoCyc);
        if (twoCyc) begin
            @(posedge ref_clk);
            ioReadData <= ~iod;
            #1;
            check(opDone, 1'b1);
            check(opReady, 1'b1);
        end
    endtask : runOp

    function automatic logic takeOf(input op_t op, input logic [7:0] f);
        case (op)
            BRANCH_CARRY_ZERO, BRANCH_SAME_OR_HIGHER: takeOf = !f[`FLAG_C];
            BRANCH_BELOW: takeOf = f[`FLAG_C];
            BRANCH_NEGATIVE: takeOf = f[`FLAG_N];
            BRANCH_NONNEGATIVE: takeOf = !f[`FLAG_N];
            BRANCH_SIGNED_GE: takeOf = !(f[`FLAG_N] ^ f[`FLAG_V]);
            BRANCH_SIGNED_LESS: takeOf = f[`FLAG_N] ^ f[`FLAG_V];
            BRANCH_HALFCARRY_SET: takeOf = f[`FLAG_H];
            BRANCH_HALFCARRY_CLEAR: takeOf = !f[`FLAG_H];
            BRANCH_TRANSFER_FLAG_SET: takeOf = f[`FLAG_T];
            BRANCH_IRQ_ON: takeOf = f[`FLAG_I];
            BRANCH_IRQ_OFF: takeOf = !f[`FLAG_I];
            default: takeOf = 1'b0;
        endcase
    endfunction : takeOf

    // expected shift result and flags from old value and old flags
    task automatic shiftExp(input op_t op, input logic [7:0] v, input logic [7:0] f,
            output logic [7:0] r, output logic [7:0] nf);
        logic c;
        case (op)
            SHIFT_LEFT_ZERO_FILL: {c, r} = {v, 1'b0};
            SHIFT_RIGHT_ZERO_FILL: {r, c} = {1'b0, v};
            ROTATE_LEFT_CARRY: {c, r} = {v, f[`FLAG_C]};
            ROTATE_RIGHT_CARRY: {r, c} = {f[`FLAG_C], v};
            default: {r, c} = {v[7], v};
        endcase
        nf = f;
        nf[`FLAG_C] = c;
        nf[`FLAG_Z] = (r == 8'h00);
        nf[`FLAG_N] = r[7];
        nf[`FLAG_V] = r[7] ^ c;
    endtask : shiftExp

    task automatic ioCase(input op_t op, input logic [2:0] b, input logic [7:0] iod,
            input logic [7:0] exp);
        runOp(op, 7'h00, b, 8'h00, 8'h00, iod, 1'b1);
        expPc = expPc + 13'h1;
        check(ioWriteStrobe, 1'b1);
        check(ioWriteAddr, 5'h1a);
        check(ioWriteData, exp);
        check(flags, 8'ha5);
        check(pc, expPc);
    endtask : ioCase

    initial begin
        op_t op;
        logic [7:0] f;
        logic [7:0] r;
        logic [7:0] nf;
        logic [7:0] e;
        logic [6:0] k;
        logic t;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(pc, 13'h0000);
        check(flags, 8'h00);
        check(opReady, 1'b1);
        // every branch against four flag patterns, offsets at both ends
        for (int i = 1; i <= 12; i++) begin
            for (int j = 0; j < 4; j++) begin
                op = op_t'(i);
                f = pats[j];
                setFlags(f);
                t = takeOf(op, f);
                k = j[0] ? 7'h40 : 7'h3f;
                runOp(op, k, 3'h0, 8'h00, 8'h00, 8'h00, t);
                expPc = t ? expPc + {{6{k[6]}}, k} + 13'h1 : expPc + 13'h1;
                check(pc, expPc);
                check(flags, f);
            end
        end
        // shifts and rotates with old carry clear and set
        for (int i = 15; i <= 19; i++) begin
            for (int j = 0; j < 4; j++) begin
                op = op_t'(i);
                f = j[0] ? 8'hf1 : 8'h0e;
                e = (j == 0) ? 8'h80 : (j == 1) ? 8'h01 : (j == 2) ? 8'h00 : 8'h7e;
                setFlags(f);
                shiftExp(op, e, f, r, nf);
                runOp(op, 7'h00, 3'h0, e, 8'h00, 8'h00, 1'b0);
                expPc = expPc + 13'h1;
                check(rdWrite, 1'b1);
                check(rdWriteIndex, 5'h0b);
                check(rdWriteData, r);
                check(flags, nf);
                check(pc, expPc);
            end
        end
        setFlags(8'h5a);
        runOp(NIBBLE_EXCHANGE, 7'h00, 3'h0, 8'h3c, 8'h00, 8'h00, 1'b0);
        expPc = expPc + 13'h1;
        check(rdWriteData, 8'hc3);
        check(flags, 8'h5a);
        // set every flag one by one, then clear them one by one
        setFlags(8'h00);
        e = 8'h00;
        for (int s = 0; s < 16; s++) begin
            runOp(s < 8 ? FLAG_SET_OP : FLAG_CLEAR_OP, 7'h00, s[2:0], 8'h00, 8'h00,
                8'h00, 1'b0);
            expPc = expPc + 13'h1;
            e[s[2:0]] = (s < 8);
            check(flags, e);
            check(pc, expPc);
        end
        setFlags(8'h81);
        runOp(BIT_TO_TRANSFER_FLAG, 7'h00, 3'h4, 8'h00, 8'h10, 8'h00, 1'b0);
        check(flags, 8'hc1);
        runOp(BIT_TO_TRANSFER_FLAG, 7'h00, 3'h3, 8'h00, 8'hf7, 8'h00, 1'b0);
        check(flags, 8'h81);
        setFlags(8'h40);
        runOp(TRANSFER_FLAG_TO_BIT, 7'h00, 3'h5, 8'h00, 8'h00, 8'h00, 1'b0);
        check(rdWrite, 1'b1);
        check(rdWriteData, 8'h20);
        check(flags, 8'h40);
        setFlags(8'h00);
        runOp(TRANSFER_FLAG_TO_BIT, 7'h00, 3'h2, 8'hff, 8'h00, 8'h00, 1'b0);
        check(rdWriteData, 8'hfb);
        expPc = expPc + 13'h5;
        setFlags(8'ha5);
        runOp(OP_NOP, 7'h00, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0);
        ioCase(IO_BIT_SET_OP, 3'h0, 8'h5a, 8'h5b);
        ioCase(IO_BIT_SET_OP, 3'h7, 8'h5a, 8'hda);
        ioCase(IO_BIT_CLEAR_OP, 3'h1, 8'h5a, 8'h58);
        ioCase(IO_BIT_CLEAR_OP, 3'h6, 8'hff, 8'hbf);
        // second io op taken in the write cycle of the first, read data left stale
        @(posedge ref_clk);
        opValid <= 1'b1;
        opCode <= IO_BIT_SET_OP;
        bitSel <= 3'h3;
        @(posedge ref_clk);
        opValid <= 1'b0;
        ioReadData <= 8'h41;
        @(posedge ref_clk);
        opValid <= 1'b1;
        opCode <= IO_BIT_CLEAR_OP;
        bitSel <= 3'h0;
        #1;
        check(ioWriteData, 8'h49);
        check(opReady, 1'b1);
        @(posedge ref_clk);
        opValid <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(ioWriteData, 8'h48);
        expPc = expPc + 13'h2;
        check(pc, expPc);
        repeat (2) @(posedge ref_clk);
        stopTest();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        nErrors++;
        stopTest();
    end
endmodule : branch_and_bit_op_exec_tb

// file: branch_cond.sv
`timescale 1ns/1ps
`include "exec_defs.svh"

module branch_cond
    import exec_pkg::*;
(
    input wire op_t opCode,
    input wire logic [7:0] flags,
    output logic take
);
    always_comb begin
        case (opCode)
            BRANCH_CARRY_ZERO: take = !flags[`FLAG_C];
            BRANCH_SAME_OR_HIGHER: take = !flags[`FLAG_C];
            BRANCH_BELOW: take = flags[`FLAG_C];
            BRANCH_NEGATIVE: take = flags[`FLAG_N];
            BRANCH_NONNEGATIVE: take = !flags[`FLAG_N];
            BRANCH_SIGNED_GE: take = !(flags[`FLAG_N] ^ flags[`FLAG_V]);
            BRANCH_SIGNED_LESS: take = flags[`FLAG_N] ^ flags[`FLAG_V];
            BRANCH_HALFCARRY_SET: take = flags[`FLAG_H];
            BRANCH_HALFCARRY_CLEAR: take = !flags[`FLAG_H];
            BRANCH_TRANSFER_FLAG_SET: take = flags[`FLAG_T];
            BRANCH_IRQ_ON: take = flags[`FLAG_I];
            BRANCH_IRQ_OFF: take = !flags[`FLAG_I];
            default: take = 1'b0;
        endcase
    end
endmodule : branch_cond

// file: exec_defs.svh
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define PC_WIDTH 13
`define PC_RESET 13'h0000
`define FLAGS_RESET 8'h00
`define REG_INDEX_WIDTH 5
`define IO_ADDR_WIDTH 5
`define OFFSET_WIDTH 7

`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

`endif

// file: exec_pkg.sv
package exec_pkg;

    typedef enum logic [4:0] {
        OP_NOP,
        BRANCH_CARRY_ZERO,
        BRANCH_SAME_OR_HIGHER,
        BRANCH_BELOW,
        BRANCH_NEGATIVE,
        BRANCH_NONNEGATIVE,
        BRANCH_SIGNED_GE,
        BRANCH_SIGNED_LESS,
        BRANCH_HALFCARRY_SET,
        BRANCH_HALFCARRY_CLEAR,
        BRANCH_TRANSFER_FLAG_SET,
        BRANCH_IRQ_ON,
        BRANCH_IRQ_OFF,
        IO_BIT_SET_OP,
        IO_BIT_CLEAR_OP,
        SHIFT_LEFT_ZERO_FILL,
        SHIFT_RIGHT_ZERO_FILL,
        ROTATE_LEFT_CARRY,
        ROTATE_RIGHT_CARRY,
        SHIFT_RIGHT_SIGN_KEEP,
        NIBBLE_EXCHANGE,
        FLAG_SET_OP,
        FLAG_CLEAR_OP,
        BIT_TO_TRANSFER_FLAG,
        TRANSFER_FLAG_TO_BIT
    } op_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_FLUSH,
        PH_IO_MOD
    } phase_t;

    function automatic logic isBranch(input op_t op);
        isBranch = (op >= BRANCH_CARRY_ZERO) && (op <= BRANCH_IRQ_OFF);
    endfunction : isBranch

    function automatic logic isRegOp(input op_t op);
        isRegOp = ((op >= SHIFT_LEFT_ZERO_FILL) && (op <= NIBBLE_EXCHANGE))
            || (op == TRANSFER_FLAG_TO_BIT);
    endfunction : isRegOp

endpackage : exec_pkg

// file: shift_unit.sv
`timescale 1ns/1ps
`include "exec_defs.svh"

module shift_unit
    import exec_pkg::*;
(
    input wire op_t opCode,
    input wire logic [7:0] operand,
    input wire logic [7:0] flagsIn,
    input wire logic [2:0] bitSel,
    output logic [7:0] result,
    output logic [7:0] flagsOut
);
    logic carryOut;
    logic arith;

    always_comb begin
        result = operand;
        carryOut = flagsIn[`FLAG_C];
        arith = 1'b1;
        case (opCode)
            SHIFT_LEFT_ZERO_FILL: begin
                result = {operand[6:0], 1'b0};
                carryOut = operand[7];
            end
            SHIFT_RIGHT_ZERO_FILL: begin
                result = {1'b0, operand[7:1]};
                carryOut = operand[0];
            end
            ROTATE_LEFT_CARRY: begin
                result = {operand[6:0], flagsIn[`FLAG_C]};
                carryOut = operand[7];
            end
            ROTATE_RIGHT_CARRY: begin
                result = {flagsIn[`FLAG_C], operand[7:1]};
                carryOut = operand[0];
            end
            SHIFT_RIGHT_SIGN_KEEP: begin
                result = {operand[7], operand[7:1]};
                carryOut = operand[0];
            end
            NIBBLE_EXCHANGE: begin
                result = {operand[3:0], operand[7:4]};
                arith = 1'b0;
            end
            TRANSFER_FLAG_TO_BIT: begin
                result[bitSel] = flagsIn[`FLAG_T];
                arith = 1'b0;
            end
            default: arith = 1'b0;
        endcase
        flagsOut = flagsIn;
        if (arith) begin
            flagsOut[`FLAG_Z] = (result == 8'h00);
            flagsOut[`FLAG_C] = carryOut;
            flagsOut[`FLAG_N] = result[7];
            flagsOut[`FLAG_V] = result[7] ^ carryOut;
        end
    end
endmodule : shift_unit
